/* rtl/ucf_regs.sv */
// Cell header filter, look-up addressing, parity count, loopback and FIFO
// control registers of the cell interface.
// Assumes a same-clock host port and a receive link on its own clock.
`default_nettype none


module ucf_regs #(
  parameter int  RX_DEPTH   = 4,
  parameter int  TX_DEPTH   = 4,
  parameter bit  ODD_PARITY = 1'b1
) (
  input  wire logic        clk,            // Core clock.
  input  wire logic        rst_b,          // Asynchronous reset, active low.
  input  wire logic        rx_link_clk,    // Receive link clock.
  input  wire logic [15:0] rx_cell_bus,    // Receive link data word.
  input  wire logic        rx_cell_parity, // Receive link parity bit.
  input  wire logic        rx_cell_soc,    // First word of a cell.
  input  wire logic        rx_word_valid,  // Word present on the link.
  input  wire logic        cpu_sel,        // Host access strobe.
  input  wire logic        cpu_wr,         // Host write when high.
  input  wire logic [15:0] cpu_addr,       // Host byte address.
  input  wire logic [15:0] cpu_wdata,      // Host write data.
  output var  logic [15:0] cpu_rdata,      // Host read data.
  output var  logic        cpu_ack,        // Host access done.
  input  wire logic        uni_mode,       // UNI header when high.
  input  wire logic [3:0]  vpi_bits_cnt,   // VPI bits in the look-up.
  input  wire logic [4:0]  vci_bits_cnt,   // VCI bits in the look-up.
  output var  logic        lut_req,        // Look-up address valid.
  output var  logic [20:0] lut_addr,       // Look-up byte address.
  output var  logic [31:0] core_hdr,       // Accepted cell header.
  output var  logic        core_valid,     // Accepted header valid.
  input  wire logic        core_ready,     // Core takes the header.
  output var  logic [31:0] tx_hdr,         // Outgoing cell header.
  output var  logic        tx_valid,       // Outgoing header valid.
  input  wire logic        tx_ready        // Outgoing side takes it.
);
  localparam int HW = ucf_pkg::HDR_W;

  // Refuse FIFO depths the queues cannot serve.
  if (RX_DEPTH < 2 || TX_DEPTH < 2) begin : g_bad_depth
    $error("ucf_regs FIFO depths must be at least 2");
  end

  // Mask of the k low bits.
  function automatic logic [31:0] low_mask(input logic [4:0] k);
    return (32'h1 << k) - 32'h1;
  endfunction

  // A field passes when no enabled bit differs from its match value.
  function automatic logic bits_ok(input logic [15:0] val,
                                   input logic [15:0] en,
                                   input logic [15:0] x);
    return ((val ^ x) & en) == 16'h0;
  endfunction

  // Receive link domain.
  ucf_pkg::ucf_link_e lk_state_q;
  logic [4:0]         lk_cnt_q;
  logic [15:0]        hdr_hi_q;
  logic [HW-1:0]      hdr_x_q;
  logic               req_tgl_q;
  logic               par_tgl_q;
  logic               ack_s1_q;
  logic               ack_s2_q;
  logic               ack_s3_q;
  logic               par_bad;
  logic               xfer_idle;

  // Core domain.
  logic [15:0] base_q;
  logic [15:0] vci_val_q;
  logic [15:0] vci_en_q;
  logic [11:0] vpi_val_q;
  logic [11:0] vpi_en_q;
  logic [15:0] par_cnt_q;
  logic        par_roll_q;
  logic        loop_q;
  logic        tx_flush_q;
  logic        rx_flush_q;
  logic        req_s1_q;
  logic        req_s2_q;
  logic        req_s3_q;
  logic        ack_tgl_q;
  logic        par_s1_q;
  logic        par_s2_q;
  logic        par_s3_q;
  logic        par_seen_q;
  logic        hdr_new;
  logic        par_evt;
  logic        cell_pass;
  logic        cell_pass_q;
  logic [11:0] hdr_vpi;
  logic [15:0] hdr_vci;
  logic [11:0] vpi_en_eff;
  logic [15:0] lut_idx;
  logic [15:0] fcs_word;
  logic [15:0] rd_word;
  logic        wr_hit;
  logic        rd_stat;
  logic        core_take;

  logic [15:0] cpu_rdata_q;
  logic        cpu_ack_q;
  logic        lut_req_q;
  logic [20:0] lut_addr_q;
  logic [31:0] core_hdr_q;
  logic        core_valid_q;
  logic [31:0] tx_hdr_q;
  logic        tx_valid_q;

  ucf_fifo_if #(.W(HW)) rx_if ();
  ucf_fifo_if #(.W(HW)) tx_if ();

  // Parity is checked on every valid link word.
  assign par_bad   = rx_word_valid && ((^{rx_cell_bus, rx_cell_parity}) != ODD_PARITY);
  assign xfer_idle = (ack_s2_q == ack_s3_q) && (ack_s3_q == req_tgl_q);

  // Header capture walks each cell on the link clock.
  always_ff @(posedge rx_link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lk_state_q <= ucf_pkg::UCF_LK_IDLE;
      lk_cnt_q   <= 5'h00;
      hdr_hi_q   <= 16'h0000;
    end else if (rx_word_valid && rx_cell_soc) begin
      lk_state_q <= ucf_pkg::UCF_LK_HDR;
      lk_cnt_q   <= 5'h01;
      hdr_hi_q   <= rx_cell_bus;
    end else if (rx_word_valid) begin
      lk_cnt_q <= lk_cnt_q + 5'h01;
      unique case (lk_state_q)
        ucf_pkg::UCF_LK_IDLE: begin
          lk_cnt_q <= 5'h00;
        end
        ucf_pkg::UCF_LK_HDR: begin
          lk_state_q <= ucf_pkg::UCF_LK_BODY;
        end
        ucf_pkg::UCF_LK_BODY: begin
          if (lk_cnt_q == ucf_pkg::CELL_WORDS - 5'h01) begin
            lk_state_q <= ucf_pkg::UCF_LK_IDLE;
          end
        end
        default: begin
          lk_state_q <= ucf_pkg::UCF_LK_IDLE;
        end
      endcase
    end
  end

  // A full header is handed over when the last one was taken, else dropped.
  always_ff @(posedge rx_link_clk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_x_q   <= '0;
      req_tgl_q <= 1'b0;
    end else if (rx_word_valid && !rx_cell_soc && lk_state_q == ucf_pkg::UCF_LK_HDR && xfer_idle) begin
      hdr_x_q   <= {hdr_hi_q, rx_cell_bus};
      req_tgl_q <= !req_tgl_q;
    end
  end

  // Each mismatch flips a toggle that the core clock counts.
  always_ff @(posedge rx_link_clk or negedge rst_b) begin
    if (!rst_b) begin
      par_tgl_q <= 1'b0;
    end else if (par_bad) begin
      par_tgl_q <= !par_tgl_q;
    end
  end

  // Acknowledge toggle comes back through three flip-flops.
  always_ff @(posedge rx_link_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  // Request and parity toggles enter the core clock through three flip-flops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      par_s1_q <= 1'b0;
      par_s2_q <= 1'b0;
      par_s3_q <= 1'b0;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      par_s1_q <= par_tgl_q;
      par_s2_q <= par_s1_q;
      par_s3_q <= par_s2_q;
    end
  end

  // A change counts once the second and third stages agree.
  assign hdr_new = (req_s2_q == req_s3_q) && (req_s3_q != ack_tgl_q);
  assign par_evt = (par_s2_q == par_s3_q) && (par_s3_q != par_seen_q);

  // Header held stable by the link side until acknowledged.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_tgl_q  <= 1'b0;
      par_seen_q <= 1'b0;
    end else begin
      if (hdr_new) begin
        ack_tgl_q <= req_s3_q;
      end
      if (par_evt) begin
        par_seen_q <= par_s3_q;
      end
    end
  end

  // Header fields; UNI leaves the GFC out of the VPI and its compare.
  assign hdr_vpi    = uni_mode ? {4'h0, hdr_x_q[27:20]} : hdr_x_q[31:20];
  assign hdr_vci    = hdr_x_q[19:4];
  assign vpi_en_eff = uni_mode ? (vpi_en_q & ucf_pkg::UNI_VPI_MASK) : vpi_en_q;
  assign cell_pass  = bits_ok(vci_val_q, vci_en_q, hdr_vci)
                   && bits_ok({4'h0, vpi_val_q}, {4'h0, vpi_en_eff}, {4'h0, hdr_vpi});

  // Index: selected VPI bits above selected VCI bits, counts clamped.
  always_comb begin
    logic [4:0]  nn;
    logic [3:0]  mm;
    logic [31:0] v;
    v  = 32'h00000000;
    nn = vci_bits_cnt;
    mm = vpi_bits_cnt;
    if (nn < ucf_pkg::VCI_BITS_MIN) begin
      nn = ucf_pkg::VCI_BITS_MIN;
    end
    if (nn > ucf_pkg::VCI_BITS_MAX) begin
      nn = ucf_pkg::VCI_BITS_MAX;
    end
    if (mm > ucf_pkg::VPI_BITS_MAX) begin
      mm = ucf_pkg::VPI_BITS_MAX;
    end
    v = (({20'h0, hdr_vpi} & low_mask({1'b0, mm})) << nn)
      | ({16'h0, hdr_vci} & low_mask(nn));
    lut_idx = v[15:0];
  end

  // Look-up request and filter verdict for each new header.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lut_req_q   <= 1'b0;
      lut_addr_q  <= 21'h00000;
      cell_pass_q <= 1'b0;
    end else begin
      lut_req_q <= hdr_new;
      if (hdr_new) begin
        lut_addr_q  <= {base_q, 5'h00} | {4'h0, lut_idx, 1'b0};
        cell_pass_q <= cell_pass;
      end
    end
  end

  // Passing headers enter the incoming queue unless it is full or flushed; others are dropped.
  assign rx_if.wr_valid = hdr_new && cell_pass;
  assign rx_if.wr_data  = hdr_x_q;
  assign rx_if.flush    = rx_flush_q;
  assign tx_if.flush    = tx_flush_q;

  // Loopback steers the incoming queue into the outgoing one.
  assign core_take      = !core_valid_q || core_ready;
  assign rx_if.rd_ready = loop_q ? tx_if.wr_ready : core_take;
  assign tx_if.wr_valid = loop_q && rx_if.rd_valid;
  assign tx_if.wr_data  = rx_if.rd_data;
  assign tx_if.rd_ready = !tx_valid_q || tx_ready;

  ucf_fifo #(.W(HW), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .f     (rx_if.store)
  );

  ucf_fifo #(.W(HW), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .f     (tx_if.store)
  );

  // Output stages toward the core and the outgoing side.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_hdr_q   <= 32'h00000000;
      core_valid_q <= 1'b0;
      tx_hdr_q     <= 32'h00000000;
      tx_valid_q   <= 1'b0;
    end else begin
      if (core_take) begin
        core_valid_q <= !loop_q && rx_if.rd_valid;
        core_hdr_q   <= (!loop_q && rx_if.rd_valid) ? rx_if.rd_data : core_hdr_q;
      end
      if (tx_if.rd_ready) begin
        tx_valid_q <= tx_if.rd_valid;
        tx_hdr_q   <= tx_if.rd_valid ? tx_if.rd_data : tx_hdr_q;
      end
    end
  end

  // Parity mismatch counter and its sticky rollover flag; set wins over read.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      par_cnt_q  <= 16'h0000;
      par_roll_q <= 1'b0;
    end else begin
      if (par_evt) begin
        par_cnt_q <= par_cnt_q + 16'h0001;
      end
      if (par_evt && par_cnt_q == 16'hFFFF) begin
        par_roll_q <= 1'b1;
      end else if (rd_stat) begin
        par_roll_q <= 1'b0;
      end
    end
  end

  // Live FIFO control/status word.
  always_comb begin
    fcs_word                        = 16'h0000;
    fcs_word[ucf_pkg::FCS_LOOP]     = loop_q;
    fcs_word[ucf_pkg::FCS_TX_FLUSH] = tx_flush_q;
    fcs_word[ucf_pkg::FCS_RX_FLUSH] = rx_flush_q;
    fcs_word[ucf_pkg::FCS_TX_FULL]  = tx_if.full;
    fcs_word[ucf_pkg::FCS_TX_EMPTY] = tx_if.empty;
    fcs_word[ucf_pkg::FCS_RX_EMPTY] = rx_if.empty;
    fcs_word[ucf_pkg::FCS_RX_FULL]  = rx_if.full;
  end

  // Host access decode.
  assign wr_hit  = cpu_sel && cpu_wr;
  assign rd_stat = cpu_sel && !cpu_wr && cpu_addr == ucf_pkg::ADDR_STATUS;

  // Read multiplexer; unmapped addresses and reserved bits read zero.
  always_comb begin
    unique case (cpu_addr)
      ucf_pkg::ADDR_TBL_BASE: rd_word = base_q;
      ucf_pkg::ADDR_VCI_VAL:  rd_word = vci_val_q;
      ucf_pkg::ADDR_VCI_EN:   rd_word = vci_en_q;
      ucf_pkg::ADDR_VPI_VAL:  rd_word = {4'h0, vpi_val_q};
      ucf_pkg::ADDR_VPI_EN:   rd_word = {4'h0, vpi_en_q};
      ucf_pkg::ADDR_PAR_CNT:  rd_word = par_cnt_q;
      ucf_pkg::ADDR_FIFO_CS:  rd_word = fcs_word;
      ucf_pkg::ADDR_STATUS:   rd_word = 16'(par_roll_q) << ucf_pkg::STAT_PAR_ROLL;
      default:                rd_word = 16'h0000;
    endcase
  end

  // Writable registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      base_q     <= 16'h0000;
      vci_val_q  <= 16'h0000;
      vci_en_q   <= 16'h0000;
      vpi_val_q  <= 12'h000;
      vpi_en_q   <= 12'h000;
      loop_q     <= ucf_pkg::FCS_RESET[ucf_pkg::FCS_LOOP];
      tx_flush_q <= ucf_pkg::FCS_RESET[ucf_pkg::FCS_TX_FLUSH];
      rx_flush_q <= ucf_pkg::FCS_RESET[ucf_pkg::FCS_RX_FLUSH];
    end else if (wr_hit) begin
      unique case (cpu_addr)
        ucf_pkg::ADDR_TBL_BASE: base_q <= cpu_wdata;
        ucf_pkg::ADDR_VCI_VAL:  vci_val_q <= cpu_wdata;
        ucf_pkg::ADDR_VCI_EN:   vci_en_q <= cpu_wdata;
        ucf_pkg::ADDR_VPI_VAL:  vpi_val_q <= cpu_wdata[11:0];
        ucf_pkg::ADDR_VPI_EN:   vpi_en_q <= cpu_wdata[11:0];
        ucf_pkg::ADDR_FIFO_CS: begin
          loop_q     <= cpu_wdata[ucf_pkg::FCS_LOOP];
          tx_flush_q <= cpu_wdata[ucf_pkg::FCS_TX_FLUSH];
          rx_flush_q <= cpu_wdata[ucf_pkg::FCS_RX_FLUSH];
        end
        default: begin
        end
      endcase
    end
  end

  // Host answer one cycle after the strobe.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_rdata_q <= 16'h0000;
      cpu_ack_q   <= 1'b0;
    end else begin
      cpu_ack_q   <= cpu_sel;
      cpu_rdata_q <= (cpu_sel && !cpu_wr) ? rd_word : 16'h0000;
    end
  end

  assign cpu_rdata  = cpu_rdata_q;
  assign cpu_ack    = cpu_ack_q;
  assign lut_req    = lut_req_q;
  assign lut_addr   = lut_addr_q;
  assign core_hdr   = core_hdr_q;
  assign core_valid = core_valid_q;
  assign tx_hdr     = tx_hdr_q;
  assign tx_valid   = tx_valid_q;

  // Checks on the behaviour above.
  a_par_count: assert property (@(posedge clk) disable iff (!rst_b)
    par_evt |=> par_cnt_q == $past(par_cnt_q) + 16'h0001) else $error("parity count did not step");
  a_par_roll: assert property (@(posedge clk) disable iff (!rst_b)
    (par_evt && par_cnt_q == 16'hFFFF) |=> par_roll_q && par_cnt_q == 16'h0000) else $error("rollover flag missed");
  a_vci_reject: assert property (@(posedge clk) disable iff (!rst_b)
    (hdr_new && ((hdr_vci ^ vci_val_q) & vci_en_q) != 16'h0) |-> !rx_if.wr_valid ##1 !cell_pass_q)
    else $error("vci mismatch passed");
  a_open_pass: assert property (@(posedge clk) disable iff (!rst_b)
    (hdr_new && vci_en_q == 16'h0 && vpi_en_q == 12'h000) |=> cell_pass_q) else $error("open filter rejected");
  a_lut_form: assert property (@(posedge clk) disable iff (!rst_b)
    hdr_new |=> lut_req_q && lut_addr_q[20:5] == ($past(base_q) | {4'h0, $past(lut_idx[15:4])})
      && lut_addr_q[4:1] == $past(lut_idx[3:0]) && !lut_addr_q[0]) else $error("look-up address wrong");
  a_tx_flush: assert property (@(posedge clk) disable iff (!rst_b)
    tx_flush_q |=> tx_if.empty && !tx_if.rd_valid) else $error("outgoing flush left data");
  a_rx_flush: assert property (@(posedge clk) disable iff (!rst_b)
    rx_flush_q |=> rx_if.empty && !rx_if.rd_valid) else $error("incoming flush left data");
  a_loop_path: assert property (@(posedge clk) disable iff (!rst_b)
    (loop_q && rx_if.rd_valid && tx_if.wr_ready) |=> !$stable(tx_if.empty) || !tx_if.empty)
    else $error("loopback did not move a cell");
  a_reset_fcs: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> fcs_word == ucf_pkg::FCS_RESET) else $error("control/status reset value wrong");
endmodule

`default_nettype wire

/* rtl/ucf_pkg.sv */
// Constants shared by the cell filter and look-up register block.
// Assumes a 16-bit byte-addressed host port and 32-bit cell headers.
`default_nettype none

package ucf_pkg;

  // Host port byte addresses of the registers.
  localparam logic [15:0] ADDR_TBL_BASE = 16'h4004;
  localparam logic [15:0] ADDR_VCI_VAL  = 16'h4006;
  localparam logic [15:0] ADDR_VCI_EN   = 16'h4008;
  localparam logic [15:0] ADDR_VPI_VAL  = 16'h400A;
  localparam logic [15:0] ADDR_VPI_EN   = 16'h400C;
  localparam logic [15:0] ADDR_PAR_CNT  = 16'h400E;
  localparam logic [15:0] ADDR_FIFO_CS  = 16'h4010;
  localparam logic [15:0] ADDR_STATUS   = 16'h4012;

  // Field positions of the FIFO control/status register.
  localparam int FCS_LOOP     = 0;
  localparam int FCS_TX_FLUSH = 1;
  localparam int FCS_RX_FLUSH = 2;
  localparam int FCS_TX_FULL  = 3;
  localparam int FCS_TX_EMPTY = 4;
  localparam int FCS_RX_EMPTY = 5;
  localparam int FCS_RX_FULL  = 6;
  localparam logic [15:0] FCS_RESET = 16'h0030;

  // Field position of the parity rollover flag in the status register.
  localparam int STAT_PAR_ROLL = 1;

  // Header layout and look-up bit count limits.
  localparam int          HDR_W        = 32;
  localparam int          VPI_W        = 12;
  localparam logic [11:0] UNI_VPI_MASK = 12'h0FF;
  localparam logic [4:0]  VCI_BITS_MIN = 5'h04;
  localparam logic [4:0]  VCI_BITS_MAX = 5'h10;
  localparam logic [3:0]  VPI_BITS_MAX = 4'hC;
  localparam int          TBL_SHIFT    = 5;

  // Words of a cell on the 16-bit link, and link receive states.
  localparam logic [4:0] CELL_WORDS = 5'h1B;
  typedef enum logic [2:0] {
    UCF_LK_IDLE = 3'b001,
    UCF_LK_HDR  = 3'b010,
    UCF_LK_BODY = 3'b100
  } ucf_link_e;

endpackage

`default_nettype wire

/* rtl/ucf_fifo_if.sv */
// Interface carrying one FIFO's write, read, flush and flag signals.
// Assumes both sides run on the same clock.
`default_nettype none

interface ucf_fifo_if #(
  parameter int W = 32
) ();
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  logic         flush;
  logic         full;
  logic         empty;

  modport store (input wr_valid, wr_data, rd_ready, flush,
                 output wr_ready, rd_valid, rd_data, full, empty);
  modport user (output wr_valid, wr_data, rd_ready, flush,
                input wr_ready, rd_valid, rd_data, full, empty);
endinterface

`default_nettype wire

/* rtl/ucf_fifo.sv */
// Flip-flop FIFO with flush, full and empty, used for the cell queues.
// Assumes a power-of-two depth and a single clock.
`default_nettype none

module ucf_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,   // Core clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  ucf_fifo_if.store f     // Write, read and flag signals.
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths that the pointer wrap cannot serve.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ucf_fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Flags and handshakes; a flush holds the queue empty.
  assign f.full     = (cnt_q == (AW + 1)'(DEPTH));
  assign f.empty    = (cnt_q == '0);
  assign f.wr_ready = !f.full && !f.flush;
  assign f.rd_valid = !f.empty && !f.flush;
  assign f.rd_data  = mem_q[rptr_q];
  assign push       = f.wr_valid && f.wr_ready;
  assign pop        = f.rd_ready && f.rd_valid;

  // Storage is written at the write pointer.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= f.wr_data;
    end
  end

  // Pointers and fill count; flush discards every entry.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else if (f.flush) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + AW'(1);
      end
      if (pop) begin
        rptr_q <= rptr_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

`default_nettype wire

/* rtl/ucf_pkg_fix_note_unused.sv */
// Empty compilation unit kept beside the package; it holds no code.
// Assumes nothing of its surroundings.
`default_nettype none
`default_nettype wire

/* test/ucf_link_src.sv */
// Link-side cell source model sending header words on the link clock.
// Assumes the receiver takes every valid word.
`default_nettype none
module ucf_link_src (
  input  wire logic        lclk, // Link clock.
  output var  logic [15:0] d,    // Link word.
  output var  logic        par,  // Word parity.
  output var  logic        soc,  // First word of a cell.
  output var  logic        vld   // Word present.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Drives one word with odd parity, flipped when bad is set.
  task automatic word(input logic [15:0] w, input logic s, input logic bad);
    @(posedge lclk);
    d <= w;
    par <= ~^w ^ bad;
    soc <= s;
    vld <= 1'b1;
  endtask
  // Sends a header as two words, then idles with the bus inverted.
  task automatic send(input logic [31:0] h, input logic bad);
    word(h[31:16], 1'b1, bad);
    word(h[15:0], 1'b0, 1'b0);
    @(posedge lclk);
    d <= ~h[15:0];
    soc <= 1'b0;
    vld <= 1'b0;
  endtask
  // Starts idle.
  initial begin
    {d, par, soc, vld} = 19'h00000;
  end
endmodule
`default_nettype wire

/* test/ucf_regs_tb.sv */
// Self-checking bench for the cell filter register block.
// Assumes the link source model drives the receive link.
`default_nettype none
module ucf_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, lclk = 1'b0, rst_b = 1'b0, sel = 1'b0, wr = 1'b0, uni = 1'b0;
  logic [15:0] a = 16'h0000, wd = 16'h0000, rdat, d, s = 16'h0030, r, ve, vm, pe, pm, b;
  logic [3:0] mc = 4'h0;
  logic [4:0] nc = 5'h04;
  logic ack, par, soc, vld, lreq, cv, tv, ok;
  logic [20:0] la;
  logic [31:0] ch, th, h;
  int errors = 0, num_checks = 0, ncore = 0, ntx = 0, cyc = 0, n, m;
  ucf_link_src SRC (.lclk(lclk), .d(d), .par(par), .soc(soc), .vld(vld));
  ucf_regs DUT (.clk(clk), .rst_b(rst_b), .rx_link_clk(lclk), .rx_cell_bus(d), .rx_cell_parity(par),
    .rx_cell_soc(soc), .rx_word_valid(vld), .cpu_sel(sel), .cpu_wr(wr), .cpu_addr(a), .cpu_wdata(wd),
    .cpu_rdata(rdat), .cpu_ack(ack), .uni_mode(uni), .vpi_bits_cnt(mc), .vci_bits_cnt(nc), .lut_req(lreq),
    .lut_addr(la), .core_hdr(ch), .core_valid(cv), .core_ready(1'b1), .tx_hdr(th), .tx_valid(tv),
    .tx_ready(1'b1));
  // Clocks and timeout.
  always #2.5 clk = ~clk;
  initial begin
    #1.1;
    forever #7.5 lclk = ~lclk;
  end
  always @(posedge clk) begin
    cyc++;
    ncore += int'(cv === 1'b1);
    ntx += int'(tv === 1'b1);
    if (cyc > 20000) begin
      errors++;
      stop_test();
    end
  end
  function automatic logic [15:0] rnd();
    s = s ^ (s << 7);
    s = s ^ (s >> 9);
    s = s ^ (s << 8);
    return s;
  endfunction
  // Expected look-up byte address: base on top, selected VPI bits above selected VCI bits.
  function automatic logic [20:0] exp_addr(input logic [15:0] bb, input logic [11:0] vp, input logic [15:0] vc,
                                           input int nn, input int mm);
    logic [31:0] ix;
    ix = ((32'(vp) & ((32'h1 << mm) - 32'h1)) << nn) | (32'(vc) & ((32'h1 << nn) - 32'h1));
    return {bb, 5'h00} | {4'h0, ix[15:0], 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // One host access: strobe for one cycle, result one cycle later.
  task automatic acc(input logic w, input logic [15:0] ad, input logic [15:0] v);
    @(posedge clk);
    {sel, wr, a, wd} <= {1'b1, w, ad, v};
    @(posedge clk);
    sel <= 1'b0;
    #1 chk("cpu_ack", 1'b1, ack);
    r = rdat;
  endtask
  task automatic rd(input logic [15:0] ad, input logic [15:0] e);
    acc(1'b0, ad, 16'h0000);
    chk("cpu_rdata", e, r);
  endtask
  task automatic stop_test();
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 16'h4004; i <= 16'h4010; i += 2) rd(i, i == 16'h4010 ? ucf_pkg::FCS_RESET : 16'h0000);
    rd(ucf_pkg::ADDR_STATUS, 16'h0000);
    acc(1'b1, 16'h4020, 16'hFFFF);
    rd(16'h4020, 16'h0000);
    acc(1'b1, ucf_pkg::ADDR_FIFO_CS, 16'h0006);
    rd(ucf_pkg::ADDR_FIFO_CS, 16'h0036);
    SRC.send(32'h00000000, 1'b1);
    repeat (12) @(posedge clk);
    rd(ucf_pkg::ADDR_PAR_CNT, 16'h0001);
    for (int i = 0; i < 10; i++) begin
      {b, vm, ve, pm, pe, h[15:0]} = {rnd(), rnd(), rnd(), rnd() & 16'h0FFF, rnd() & 16'h0FFF, rnd()};
      uni <= i[0];
      if (i[0]) pe = pe & 16'h00FF;
      n = 4 + rnd() % 13;
      m = rnd() % ((17 - n) < 13 ? (17 - n) : 13);
      b = b & ~16'((1 << (n + m - 4)) - 1);
      {nc, mc} <= {5'(n), 4'(m)};
      h[31:16] = (i % 3 == 0) ? {pm[11:0], vm[15:12]} : rnd();
      if (i % 3 == 0) h[19:4] = vm;
      if (i[0] && i % 3 == 0) h[31:28] = rnd();
      ok = ((h[19:4] ^ vm) & ve) == 0 && ((h[31:20] ^ pm[11:0]) & pe[11:0]) == 0;
      acc(1'b1, ucf_pkg::ADDR_TBL_BASE, b);
      acc(1'b1, ucf_pkg::ADDR_VCI_VAL, vm);
      acc(1'b1, ucf_pkg::ADDR_VCI_EN, ve);
      acc(1'b1, ucf_pkg::ADDR_VPI_VAL, pm);
      acc(1'b1, ucf_pkg::ADDR_VPI_EN, pe);
      rd(ucf_pkg::ADDR_VPI_EN, pe);
      acc(1'b1, ucf_pkg::ADDR_FIFO_CS, {15'h0000, i > 6});
      {ncore, ntx} = 0;
      SRC.send(h, 1'b0);
      for (int k = 0; k < 40 && lreq !== 1'b1; k++) #5;
      chk("lut_req", 1'b1, lreq);
      chk("lut_addr", exp_addr(b, i[0] ? {4'h0, h[27:20]} : h[31:20], h[19:4], n, m), la);
      repeat (10) @(posedge clk);
      chk("headers", ok, i > 6 ? ntx : ncore);
      if (ok) chk("header", h, i > 6 ? th : ch);
    end
    stop_test();
  end
endmodule
`default_nettype wire
